/* logic/spsm_socket.sv */
`timescale 1ns/100ps
`include "spsm_consts.svh"

module spsm_socket (
    input  wire logic              clk,
    input  wire logic              rst,
    input  wire logic              mgmt_wr,
    input  wire logic [1:0]        mgmt_flags,
    input  wire logic              ib_valid,
    input  wire logic              ib_solicited,
    input  wire logic              ib_marker,
    input  wire logic              ob_valid,
    output spsm_pkg::spsm_mode_t   mode,
    output logic                   drained,
    output logic                   plugin_reset,
    output logic                   ib_post,
    output logic                   ob_take,
    output logic                   marker_req,
    output logic                   reset_release
);
    import spsm_pkg::*;

    spsm_sock_state_t s_reg;
    spsm_sock_state_t s_next;

    // ----------------------------------------------------------------
    // state machine
    // ----------------------------------------------------------------
    always_comb begin
        s_next               = s_reg;
        s_next.marker_req    = 1'b0;
        s_next.reset_release = 1'b0;
        if (mgmt_wr) begin
            // anything not listed keeps the state; invalid flags never match
            unique case (s_reg.mode)
                mode_online: begin
                    if (mgmt_flags == `SPSM_FLAGS_OFFLINE) begin
                        s_next.mode       = mode_offline;
                        s_next.marker_req = 1'b1;
                        // fresh drain each exit, else a late marker seen while still offline, in the cycle of the online write, would block this one
                        s_next.drained    = 1'b0;
                    end
                end
                mode_offline: begin
                    if (mgmt_flags == `SPSM_FLAGS_ONLINE) begin
                        s_next.mode    = mode_online;
                        s_next.drained = 1'b0;
                    end else if (mgmt_flags == `SPSM_FLAGS_DISABLED) begin
                        s_next.mode = mode_disabled;
                    end
                end
                mode_disabled: begin
                    // no path to online here: reset only via offline
                    if (mgmt_flags == `SPSM_FLAGS_OFFLINE) begin
                        s_next.mode          = mode_offline;
                        s_next.reset_release = 1'b1;
                    end
                end
                default: s_next.mode = mode_disabled;
            endcase
        end
        s_next.plugin_reset = (s_next.mode == mode_disabled);
        // marker itself still gets through while offline and not yet drained
        s_next.ib_post = ib_valid && ((s_reg.mode == mode_online) ||
                         ((s_reg.mode == mode_offline) && (ib_solicited ||
                          (ib_marker && !s_reg.drained))));
        if ((s_reg.mode == mode_offline) && ib_valid && ib_marker) begin
            s_next.drained = 1'b1;
        end
        s_next.ob_take = ob_valid && (s_reg.mode != mode_disabled);
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            s_reg <= '{mode: mode_disabled, plugin_reset: 1'b1, default: 1'b0};
        end else begin
            s_reg <= s_next;
        end
    end

    assign mode          = s_reg.mode;
    assign drained       = s_reg.drained;
    assign plugin_reset  = s_reg.plugin_reset;
    assign ib_post       = s_reg.ib_post;
    assign ob_take       = s_reg.ob_take;
    assign marker_req    = s_reg.marker_req;
    assign reset_release = s_reg.reset_release;

endmodule : spsm_socket

/* logic/spsm_top.sv */
`timescale 1ns/100ps
`include "spsm_consts.svh"

module spsm_top #(
    parameter int          ADDR_W    = 32,
    parameter logic [31:0] BASE_ADDR = 32'h0000_0000
) (
    input  wire logic                                clk,
    input  wire logic                                rst,
    // register port of the general port space
    input  wire logic                                reg_wr,
    input  wire logic                                reg_rd,
    input  wire logic [ADDR_W-1:0]                   reg_addr,
    input  wire logic [31:0]                         reg_wdata,
    output logic      [31:0]                         reg_rdata,
    output logic                                     reg_rd_valid,
    // list fifos kept outside this block
    input  wire logic [`SPSM_NUM_SOCKETS-1:0][31:0]  ob_free_data,
    input  wire logic [`SPSM_NUM_SOCKETS-1:0][31:0]  ib_pend_data,
    output logic      [`SPSM_NUM_SOCKETS-1:0]        ob_free_pop,
    output logic      [`SPSM_NUM_SOCKETS-1:0]        ob_work_push,
    output logic      [`SPSM_NUM_SOCKETS-1:0]        ib_pend_pop,
    output logic      [`SPSM_NUM_SOCKETS-1:0]        ib_work_push,
    output logic      [31:0]                         push_data,
    // plug-in side, one bit per socket
    input  wire logic [`SPSM_NUM_SOCKETS-1:0]        ib_valid,
    input  wire logic [`SPSM_NUM_SOCKETS-1:0]        ib_solicited,
    input  wire logic [`SPSM_NUM_SOCKETS-1:0]        ib_marker,
    input  wire logic [`SPSM_NUM_SOCKETS-1:0]        ob_valid,
    output logic      [`SPSM_NUM_SOCKETS-1:0]        plugin_reset,
    output logic      [`SPSM_NUM_SOCKETS-1:0]        ib_post,
    output logic      [`SPSM_NUM_SOCKETS-1:0]        ob_take,
    output logic      [`SPSM_NUM_SOCKETS-1:0]        marker_req,
    output logic      [`SPSM_NUM_SOCKETS-1:0]        reset_release
);
    import spsm_pkg::*;

    localparam int N  = `SPSM_NUM_SOCKETS;
    localparam int LO = `SPSM_SLOT_BITS + `SPSM_SOCK_BITS;

    // ----------------------------------------------------------------
    // address decode
    // ----------------------------------------------------------------
    logic [`SPSM_SLOT_BITS-1:0] slot;
    logic [`SPSM_SOCK_BITS-1:0] sock;
    logic                       hit;
    logic [1:0]                 wr_flags;
    logic [N-1:0]               mgmt_wr;
    logic [N-1:0]               mgmt_rd;
    logic [N-1:0]               drained_w;
    spsm_mode_t                 mode_w [N];

    assign slot     = reg_addr[`SPSM_SLOT_BITS-1:0];
    assign sock     = reg_addr[LO-1:`SPSM_SLOT_BITS];
    // sockets sit back to back above one shared base
    assign hit      = (reg_addr[ADDR_W-1:LO] == BASE_ADDR[ADDR_W-1:LO]);
    // only the two low bits carry meaning; the rest is dropped
    assign wr_flags = reg_wdata[`SPSM_BIT_ACTIVE:`SPSM_BIT_RELEASE];

    // ----------------------------------------------------------------
    // sockets
    // ----------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < N; gi++) begin : g_sock
            assign mgmt_wr[gi] = reg_wr && hit && (sock == `SPSM_SOCK_BITS'(gi)) &&
                                 (slot == `SPSM_OFF_MGMT);
            assign mgmt_rd[gi] = reg_rd && hit && (sock == `SPSM_SOCK_BITS'(gi)) &&
                                 (slot == `SPSM_OFF_MGMT);
            spsm_socket u_sock (
                .clk           (clk),
                .rst           (rst),
                .mgmt_wr       (mgmt_wr[gi]),
                .mgmt_flags    (wr_flags),
                .ib_valid      (ib_valid[gi]),
                .ib_solicited  (ib_solicited[gi]),
                .ib_marker     (ib_marker[gi]),
                .ob_valid      (ob_valid[gi]),
                .mode          (mode_w[gi]),
                .drained       (drained_w[gi]),
                .plugin_reset  (plugin_reset[gi]),
                .ib_post       (ib_post[gi]),
                .ob_take       (ob_take[gi]),
                .marker_req    (marker_req[gi]),
                .reset_release (reset_release[gi])
            );
        end
    endgenerate

    // ----------------------------------------------------------------
    // register access
    // ----------------------------------------------------------------
    spsm_bus_state_t b_reg;
    spsm_bus_state_t b_next;

    always_comb begin
        b_next              = b_reg;
        b_next.rd_valid     = reg_rd;
        b_next.rdata        = `SPSM_ZERO_WORD;
        b_next.ob_free_pop  = '0;
        b_next.ob_work_push = '0;
        b_next.ib_pend_pop  = '0;
        b_next.ib_work_push = '0;
        // unmapped and reserved slots read zero and raise nothing
        if (reg_rd && hit) begin
            unique case (slot)
                `SPSM_OFF_OB_FREE: begin
                    b_next.rdata             = ob_free_data[sock];
                    b_next.ob_free_pop[sock] = 1'b1;
                end
                `SPSM_OFF_IB_PEND: begin
                    b_next.rdata             = ib_pend_data[sock];
                    b_next.ib_pend_pop[sock] = 1'b1;
                end
                `SPSM_OFF_MGMT: begin
                    b_next.rdata = {`SPSM_ZERO_HIGH, spsm_flags(mode_w[sock])};
                end
                default: b_next.rdata = `SPSM_ZERO_WORD;
            endcase
        end
        // read-only and reserved slots ignore writes silently; write-only slots read back zero
        if (reg_wr && hit) begin
            unique case (slot)
                `SPSM_OFF_OB_WORK: begin
                    b_next.ob_work_push[sock] = 1'b1;
                    b_next.push_data          = reg_wdata;
                end
                `SPSM_OFF_IB_WORK: begin
                    b_next.ib_work_push[sock] = 1'b1;
                    b_next.push_data          = reg_wdata;
                end
                default: b_next.push_data = b_reg.push_data;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            b_reg <= '0;
        end else begin
            b_reg <= b_next;
        end
    end

    assign reg_rd_valid = b_reg.rd_valid;
    assign reg_rdata    = b_reg.rdata;
    assign ob_free_pop  = b_reg.ob_free_pop;
    assign ob_work_push = b_reg.ob_work_push;
    assign ib_pend_pop  = b_reg.ib_pend_pop;
    assign ib_work_push = b_reg.ib_work_push;
    assign push_data    = b_reg.push_data;

    // ----------------------------------------------------------------
    // checks on the bus side
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    logic rsv_rd;
    logic misc_rd;
    assign rsv_rd  = reg_rd && hit && ((slot == `SPSM_OFF_RSV_A) || (slot == `SPSM_OFF_RSV_B) ||
                     (slot == `SPSM_OFF_RSV_C));
    // write-only slots and unmapped addresses must look the same as reserved ones
    assign misc_rd = reg_rd && (!hit || (slot == `SPSM_OFF_OB_WORK) || (slot == `SPSM_OFF_IB_WORK));

    reserved_reads_zero_a : assert property (rsv_rd |=> reg_rd_valid && (reg_rdata == `SPSM_ZERO_WORD)
        && (ob_free_pop == '0) && (ib_pend_pop == '0))
        else $error("reserved slot returned data or popped a list");

    unmapped_reads_zero_a : assert property (misc_rd |=> (reg_rdata == `SPSM_ZERO_WORD))
        else $error("write-only or unmapped slot returned data");

    rd_valid_timing_a : assert property (reg_rd |=> reg_rd_valid ##1 (reg_rd_valid == $past(reg_rd)))
        else $error("read answer not one cycle after the request");

    push_one_socket_a : assert property ($onehot0(ob_work_push) && $onehot0(ib_work_push)
        && $onehot0(ob_free_pop) && $onehot0(ib_pend_pop))
        else $error("list strobe reached more than one socket");

    reset_all_disabled_a : assert property ($fell(rst) |-> (plugin_reset == '1) && !reg_rd_valid)
        else $error("sockets not disabled after reset");

    // ----------------------------------------------------------------
    // checks per socket
    // ----------------------------------------------------------------
    generate
        for (gi = 0; gi < N; gi++) begin : g_chk
            logic [`SPSM_SOCK_BITS-1:0] me;
            logic                       sel_rd;
            logic                       sel_wr;
            assign me     = `SPSM_SOCK_BITS'(gi);
            assign sel_rd = reg_rd && hit && (sock == me);
            assign sel_wr = reg_wr && hit && (sock == me);

            sequence leave_online;
                (mode_w[gi] == mode_online) && mgmt_wr[gi] && (wr_flags == `SPSM_FLAGS_OFFLINE);
            endsequence
            sequence one_marker;
                marker_req[gi] && (mode_w[gi] == mode_offline) ##1 !marker_req[gi];
            endsequence
            sequence wake_disabled;
                (mode_w[gi] == mode_disabled) && mgmt_wr[gi] && (wr_flags == `SPSM_FLAGS_OFFLINE);
            endsequence
            sequence released;
                !plugin_reset[gi] && reset_release[gi] && (mode_w[gi] == mode_offline);
            endsequence

            reset_tracks_mode_a : assert property (plugin_reset[gi] == (mode_w[gi] == mode_disabled))
                else $error("plug-in reset disagrees with disabled state");

            flags_readback_a : assert property (mgmt_rd[gi] |=> (reg_rdata ==
                {`SPSM_ZERO_HIGH, spsm_flags($past(mode_w[gi]))}))
                else $error("management read does not show present state");

            invalid_write_kept_a : assert property (mgmt_wr[gi] && (wr_flags == `SPSM_FLAGS_INVALID)
                |=> $stable(mode_w[gi]))
                else $error("invalid flag write changed the state");

            no_write_no_move_a : assert property (!mgmt_wr[gi] |=> $stable(mode_w[gi]))
                else $error("state moved without a management write");

            online_not_reset_a : assert property ((mode_w[gi] == mode_online) |=>
                (mode_w[gi] != mode_disabled) && !plugin_reset[gi])
                else $error("online plug-in went straight into reset");

            disabled_not_online_a : assert property ((mode_w[gi] == mode_disabled) |=>
                (mode_w[gi] != mode_online))
                else $error("disabled plug-in jumped to online");

            marker_on_exit_a : assert property (leave_online |=> one_marker)
                else $error("leaving online did not give exactly one marker request");

            marker_only_exit_a : assert property (marker_req[gi] |-> $past(mode_w[gi]) == mode_online)
                else $error("marker requested outside an online exit");

            release_on_wake_a : assert property (wake_disabled |=> released ##1 !reset_release[gi])
                else $error("release from disabled did not free reset");

            hold_on_disable_a : assert property ((mode_w[gi] == mode_offline) && mgmt_wr[gi]
                && (wr_flags == `SPSM_FLAGS_DISABLED) |=> plugin_reset[gi] [*2])
                else $error("clearing release from offline did not hold reset");

            disabled_blocks_a : assert property ((mode_w[gi] == mode_disabled) |=>
                !ob_take[gi] && !ib_post[gi])
                else $error("disabled plug-in passed traffic");

            online_passes_a : assert property ((mode_w[gi] == mode_online) && ib_valid[gi] && ob_valid[gi]
                |=> ib_post[gi] && ob_take[gi])
                else $error("online plug-in blocked traffic");

            offline_drops_a : assert property ((mode_w[gi] == mode_offline) && ib_valid[gi]
                && !ib_solicited[gi] && !ib_marker[gi] |=> !ib_post[gi])
                else $error("offline plug-in posted unsolicited inbound");

            offline_solicited_a : assert property ((mode_w[gi] == mode_offline) && ib_valid[gi]
                && ib_solicited[gi] && ob_valid[gi] |=> ib_post[gi] && ob_take[gi])
                else $error("offline plug-in blocked solicited or outbound");

            drained_quiet_a : assert property ((mode_w[gi] == mode_offline) && drained_w[gi] && ib_valid[gi]
                && !ib_solicited[gi] |=> !ib_post[gi])
                else $error("inbound frame posted after the marker");

            free_pop_route_a : assert property (sel_rd && (slot == `SPSM_OFF_OB_FREE) |=>
                ob_free_pop[gi] && (reg_rdata == $past(ob_free_data[gi])))
                else $error("free-list read took wrong socket or data");

            pend_pop_route_a : assert property (sel_rd && (slot == `SPSM_OFF_IB_PEND) |=>
                ib_pend_pop[gi] && (reg_rdata == $past(ib_pend_data[gi])))
                else $error("pending-list read took wrong socket or data");

            work_push_route_a : assert property (sel_wr && (slot == `SPSM_OFF_OB_WORK) |=>
                ob_work_push[gi] && (push_data == $past(reg_wdata)))
                else $error("outbound work write lost or misrouted");

            inb_push_route_a : assert property (sel_wr && (slot == `SPSM_OFF_IB_WORK) |=>
                ib_work_push[gi] && (push_data == $past(reg_wdata)))
                else $error("inbound work write lost or misrouted");
        end
    endgenerate

endmodule : spsm_top

/* shared/spsm_consts.svh */
`ifndef SPSM_CONSTS_SVH
`define SPSM_CONSTS_SVH


// ----------------------------------------------------------------
// socket map
// ----------------------------------------------------------------
`define SPSM_NUM_SOCKETS    4
`define SPSM_SOCK_BITS      2
`define SPSM_SLOT_BITS      5
`define SPSM_OFF_OB_FREE    5'h00
`define SPSM_OFF_OB_WORK    5'h04
`define SPSM_OFF_IB_PEND    5'h08
`define SPSM_OFF_IB_WORK    5'h0C
`define SPSM_OFF_RSV_A      5'h10
`define SPSM_OFF_RSV_B      5'h14
`define SPSM_OFF_RSV_C      5'h18
`define SPSM_OFF_MGMT       5'h1C

// ----------------------------------------------------------------
// management fields
// ----------------------------------------------------------------
`define SPSM_BIT_RELEASE    0
`define SPSM_BIT_ACTIVE     1
`define SPSM_FLAGS_DISABLED 2'h0
`define SPSM_FLAGS_OFFLINE  2'h1
`define SPSM_FLAGS_INVALID  2'h2
`define SPSM_FLAGS_ONLINE   2'h3
`define SPSM_ZERO_WORD      32'h0000_0000
`define SPSM_ZERO_HIGH      30'h0000_0000

`endif

/* shared/spsm_pkg.sv */
`include "spsm_consts.svh"

package spsm_pkg;

    typedef enum logic [1:0] {
        mode_disabled,
        mode_offline,
        mode_online
    } spsm_mode_t;

    typedef struct packed {
        spsm_mode_t mode;
        logic       drained;
        logic       plugin_reset;
        logic       ib_post;
        logic       ob_take;
        logic       marker_req;
        logic       reset_release;
    } spsm_sock_state_t;

    typedef struct packed {
        logic                         rd_valid;
        logic [31:0]                  rdata;
        logic [`SPSM_NUM_SOCKETS-1:0] ob_free_pop;
        logic [`SPSM_NUM_SOCKETS-1:0] ob_work_push;
        logic [`SPSM_NUM_SOCKETS-1:0] ib_pend_pop;
        logic [`SPSM_NUM_SOCKETS-1:0] ib_work_push;
        logic [31:0]                  push_data;
    } spsm_bus_state_t;

    function automatic logic [1:0] spsm_flags(input spsm_mode_t m);
        unique case (m)
            mode_disabled: spsm_flags = `SPSM_FLAGS_DISABLED;
            mode_offline:  spsm_flags = `SPSM_FLAGS_OFFLINE;
            mode_online:   spsm_flags = `SPSM_FLAGS_ONLINE;
            default:       spsm_flags = `SPSM_FLAGS_DISABLED;
        endcase
    endfunction : spsm_flags

endpackage : spsm_pkg

/* verif/spsm_plugin_model.sv */
`timescale 1ns/100ps

module spsm_plugin_model (
    input  wire logic       clk,
    input  wire logic [3:0] send,
    input  wire logic [3:0] send_sol,
    input  wire logic [3:0] marker_req,
    input  wire logic [3:0] plugin_reset,
    output logic      [3:0] ib_valid,
    output logic      [3:0] ib_solicited,
    output logic      [3:0] ib_marker
);
    logic [3:0] mark_reg = 4'h0;

    // one marker frame per drain request, never while held
    always @(negedge clk) begin
        mark_reg <= marker_req & ~plugin_reset;
    end

    // a plug-in held in reset offers nothing inbound
    assign ib_valid     = (send | mark_reg) & ~plugin_reset;
    assign ib_marker    = mark_reg;
    assign ib_solicited = send_sol;
endmodule : spsm_plugin_model

/* verif/spsm_top_tb.sv */
`timescale 1ns/100ps

module spsm_top_tb;
    logic             clk = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, reg_rd_valid;
    logic [31:0]      reg_addr = 32'h0, reg_wdata = 32'h0, reg_rdata, push_data;
    logic [3:0][31:0] ob_free_data = {32'hD0D0_0004, 32'hC0C0_0003, 32'hB0B0_0002, 32'hA0A0_0001};
    logic [3:0][31:0] ib_pend_data;
    logic [3:0]       ob_valid = 4'h0, send = 4'h0, send_sol = 4'h0;
    logic [3:0]       ib_valid, ib_solicited, ib_marker, plugin_reset, ib_post, ob_take;
    logic [3:0]       marker_req, reset_release, ob_free_pop, ib_pend_pop, ob_work_push, ib_work_push;
    int               failures = 0, compares = 0;

    assign ib_pend_data = ~ob_free_data;
    always #2.5 clk = ~clk;

    spsm_top spsm_top_i (.clk(clk), .rst(rst), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rd_valid(reg_rd_valid),
        .ob_free_data(ob_free_data), .ib_pend_data(ib_pend_data), .ob_free_pop(ob_free_pop),
        .ob_work_push(ob_work_push), .ib_pend_pop(ib_pend_pop), .ib_work_push(ib_work_push),
        .push_data(push_data),
        .ib_valid(ib_valid), .ib_solicited(ib_solicited), .ib_marker(ib_marker), .ob_valid(ob_valid),
        .plugin_reset(plugin_reset), .ib_post(ib_post), .ob_take(ob_take), .marker_req(marker_req),
        .reset_release(reset_release));

    spsm_plugin_model spsm_plugin_model_i (.clk(clk), .send(send), .send_sol(send_sol),
        .marker_req(marker_req), .plugin_reset(plugin_reset), .ib_valid(ib_valid),
        .ib_solicited(ib_solicited), .ib_marker(ib_marker));

    // ----------------------------------------------------------------
    // access tasks
    // ----------------------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
        compares++;
        if (seen !== exp) begin
            failures++;
            $display("unexpected at %0t: %s got %0h want %0h", $time, msg, seen, exp);
        end
    endtask : check

    function automatic logic [31:0] mg(input int k);
        return k * 32'h20 + 32'h1C;
    endfunction : mg

    task automatic reg_write(input logic [31:0] a, input logic [31:0] d);
        @(negedge clk);
        {reg_wr, reg_addr, reg_wdata} = {1'b1, a, d};
        @(negedge clk);
        reg_wr = 1'b0;
    endtask : reg_write

    task automatic reg_check(input logic [31:0] a, input logic [31:0] exp, input string msg);
        @(negedge clk);
        {reg_rd, reg_addr} = {1'b1, a};
        @(negedge clk);
        reg_rd = 1'b0;
        check({31'h0, reg_rd_valid}, 32'h1, msg);
        check(reg_rdata, exp, msg);
    endtask : reg_check

    // frames cross in the cycle after the offer
    task automatic frame(input logic [3:0] ib, sol, ob, ep, et, input string msg);
        @(negedge clk);
        {send, send_sol, ob_valid} = {ib, sol, ob};
        @(negedge clk);
        {send, ob_valid} = 8'h00;
        check({28'h0, ib_post}, {28'h0, ep}, msg);
        check({28'h0, ob_take}, {28'h0, et}, msg);
    endtask : frame

    task automatic complete_run;
        $display("comparisons %0d mismatches %0d", compares, failures);
        if (failures == 0 && compares > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : complete_run

    // ----------------------------------------------------------------
    // tests
    // ----------------------------------------------------------------
    initial begin
        // five rising edges under reset
        repeat (5) @(negedge clk);
        rst = 1'b0;
        check({28'h0, plugin_reset}, 32'hF, "reset after por");
        for (int k = 0; k < 4; k++) reg_check(mg(k), 32'h0, "start disabled");
        $display("test reset done");
        reg_write(mg(0), 32'h2);
        reg_write(mg(0), 32'h3);
        reg_check(mg(0), 32'h0, "bad flags or move");
        reg_write(mg(0), 32'hFFFF_FFFD);
        check({28'h0, reset_release}, 32'h1, "release pulse");
        check({28'h0, plugin_reset}, 32'hE, "out of reset");
        reg_check(mg(0), 32'h1, "offline flags");
        frame(4'h1, 4'h0, 4'h1, 4'h0, 4'h1, "offline unsolicited");
        frame(4'h1, 4'h1, 4'h0, 4'h1, 4'h0, "offline solicited");
        reg_write(mg(0), 32'h3);
        reg_check(mg(0), 32'h3, "online flags");
        frame(4'h1, 4'h0, 4'h1, 4'h1, 4'h1, "online traffic");
        reg_write(mg(0), 32'h0);
        reg_check(mg(0), 32'h3, "no reset from online");
        reg_write(mg(0), 32'h1);
        check({28'h0, marker_req}, 32'h1, "marker request");
        @(negedge clk);
        check({28'h0, ib_post}, 32'h1, "marker posted");
        frame(4'h1, 4'h0, 4'h0, 4'h0, 4'h0, "drained");
        reg_check(mg(0), 32'h1, "offline again");
        reg_write(mg(0), 32'h0);
        frame(4'h0, 4'h0, 4'h1, 4'h0, 4'h0, "disabled drops");
        check({28'h0, plugin_reset}, 32'hF, "held in reset");
        reg_write(mg(0), 32'h1);
        check({28'h0, reset_release}, 32'h1, "reset result");
        check({28'h0, plugin_reset}, 32'hE, "released again");
        reg_write(mg(0), 32'h3);
        reg_check(mg(0), 32'h3, "back online");
        $display("test transitions done");
        reg_write(mg(3), 32'h1);
        for (int k = 0; k < 4; k++) reg_check(mg(k), {30'h0, k == 0, k == 0 || k == 3}, "per socket");
        reg_check(32'h50, 32'h0, "reserved slot");
        reg_check(32'h60, 32'hD0D0_0004, "free list");
        check({28'h0, ob_free_pop}, 32'h8, "free pop");
        reg_check(32'h28, ~32'hB0B0_0002, "pending list");
        check({28'h0, ib_pend_pop}, 32'h2, "pending pop");
        reg_write(32'h24, 32'h1234_5678);
        check({28'h0, ob_work_push}, 32'h2, "work push");
        check(push_data, 32'h1234_5678, "work data");
        reg_write(32'h6C, 32'h0BAD_F00D);
        check({28'h0, ib_work_push}, 32'h8, "inbound push");
        check(push_data, 32'h0BAD_F00D, "inbound data");
        reg_write(32'h10, 32'hFFFF_FFFF);
        check({24'h0, ob_work_push, ib_work_push}, 32'h0, "reserved write");
        check(push_data, 32'h0BAD_F00D, "data held");
        $display("test map done");
        complete_run();
    end
endmodule : spsm_top_tb
